/* File: hdl/lqta_pkg.sv */
// Constants and types for the link quality threshold access register bank
// Operation
// - Bits 15:14 of the threshold access register ignore writes and always read as zero.
// - Writing the sample request bit as one captures the selected parameter and enters parameter read mode.
// - Writing the threshold write strobe loads the data field into the threshold picked by parameter and low/high select.
// - The threshold write strobe clears itself and always reads back as zero.
// - A three-bit selector picks the parameter: 000 equalizer, 001 gain, 010 baseline wander, 011 frequency offset, 100 frequency control.
// - One select bit picks the low (0) or high (1) threshold of that parameter, ten thresholds in all.
// - With sample request clear, a write carries the threshold value in the eight-bit data field.
// - With sample request clear, a read returns the selected threshold in the data field.
// - With sample request set, a read returns the captured parameter value in the data field.
// - The captured value stays fixed until software starts a new sampling sequence.
// - Threshold writes have no effect while the device is powered down; software programs them when powered up.
// - A parameter beyond its low or high threshold sets its warning flag and raises the interrupt when enabled.
// - Monitoring runs only with its enable set and a valid 100 Mb link; an extreme threshold never trips.
package lqta_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int NUM_PARAMS = 5;
   localparam int NUM_THR = 10;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_MONITOR = 8'h1d;
   localparam logic [7:0] IDX_THR_ACCESS = 8'h1e;
   localparam logic [7:0] IDX_IRQ_ENABLE = 8'h1f;
   // Threshold access fields
   localparam int SAMPLE_BIT = 13;
   localparam int STROBE_BIT = 12;
   localparam int PSEL_HI = 11;
   localparam int PSEL_LO = 9;
   localparam int HL_BIT = 8;
   localparam int DATA_HI = 7;
   // Monitor control fields
   localparam int MON_EN_BIT = 15;
   localparam int IRQ_EN_BIT = 0;
   // Reset values
   localparam logic [7:0] THR_LOW_RESET = 8'h00;
   localparam logic [7:0] THR_HIGH_RESET = 8'hff;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      LQTA_EQ_COEF = 3'b000,
      LQTA_GAIN = 3'b001,
      LQTA_BLW = 3'b010,
      LQTA_FOFS = 3'b011,
      LQTA_FCTL = 3'b100
   } lqta_param_t;

   function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
      reg_hit = (addr[ADDR_W-1:2] == idx[ADDR_W-3:0]) && (addr[1:0] == 2'h0);
   endfunction

   function automatic logic psel_valid(input logic [2:0] psel);
      psel_valid = (psel <= LQTA_FCTL);
   endfunction
endpackage

/* File: hdl/lqta_thr_store.sv */
// Ten eight-bit thresholds, low and high for each monitored parameter
`timescale 1ns/1ps
`default_nettype none
module lqta_thr_store (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic wr_en,
   input wire logic [3:0] wr_idx,
   input wire logic [7:0] wr_data,
   input wire logic [3:0] rd_idx,
   output logic [7:0] rd_data,
   output logic [8*lqta_pkg::NUM_THR-1:0] thr_all
);
   logic [7:0] thr [lqta_pkg::NUM_THR];

   // Low resets to minimum, high to maximum: both disabled
   always_ff @(posedge aclk) begin
      for (int i = 0; i < lqta_pkg::NUM_THR; i++) begin
         if (!aresetn) begin
            thr[i] <= i[0] ? lqta_pkg::THR_HIGH_RESET : lqta_pkg::THR_LOW_RESET;
         end else if (wr_en && (wr_idx == i[3:0])) begin
            thr[i] <= wr_data;
         end
      end
   end

   always_comb begin
      rd_data = 8'h00;
      for (int i = 0; i < lqta_pkg::NUM_THR; i++) begin
         if (rd_idx == i[3:0]) begin
            rd_data = thr[i];
         end
         thr_all[8*i +: 8] = thr[i];
      end
   end

   chk_thr_load: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_en && (wr_idx < 4'ha) |=> thr[$past(wr_idx)] == $past(wr_data))
      else $error("threshold not loaded");
endmodule
`default_nettype wire

/* File: hdl/lqta_monitor.sv */
// Compares live parameters with thresholds and keeps sticky warning flags
`timescale 1ns/1ps
`default_nettype none
module lqta_monitor (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic active,
   input wire logic clear,
   input wire logic [8*lqta_pkg::NUM_PARAMS-1:0] params,
   input wire logic [8*lqta_pkg::NUM_THR-1:0] thr_all,
   output logic [lqta_pkg::NUM_THR-1:0] warn
);
   logic [lqta_pkg::NUM_THR-1:0] hit;

   // Strict compare, so 00 low and ff high never trip
   always_comb begin
      for (int p = 0; p < lqta_pkg::NUM_PARAMS; p++) begin
         hit[2*p] = active && (params[8*p +: 8] < thr_all[16*p +: 8]);
         hit[2*p+1] = active && (params[8*p +: 8] > thr_all[16*p+8 +: 8]);
      end
   end

   // A new hit in the clearing read's cycle survives the clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         warn <= '0;
      end else begin
         warn <= (clear ? '0 : warn) | hit;
      end
   end

   chk_warn_set: assert property (@(posedge aclk) disable iff (!aresetn)
      active && (params[7:0] > thr_all[15:8]) |=> warn[1])
      else $error("high warning not set");
   chk_idle_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      !active && !clear |=> $stable(warn))
      else $error("warning changed while idle");
endmodule
`default_nettype wire

/* File: hdl/lqta_top.sv */
// AXI4-Lite register bank for link quality thresholds and parameter sampling
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module lqta_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [lqta_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [lqta_pkg::DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [lqta_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [lqta_pkg::DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic pwr_down,
   input wire logic link_100_ok,
   input wire logic [7:0] equalizer_coefficient,
   input wire logic [7:0] gain_control_level,
   input wire logic [7:0] baseline_wander_level,
   input wire logic [7:0] freq_offset_level,
   input wire logic [7:0] freq_control_level,
   output logic lq_irq
);
   logic aw_held;
   logic w_held;
   logic [lqta_pkg::ADDR_W-1:0] aw_addr;
   logic [lqta_pkg::DATA_W-1:0] w_data;
   logic [3:0] w_strb;
   logic wr_do;
   logic hit_thr;
   logic hit_mon;
   logic hit_irq;
   logic [15:0] next_ctl;
   logic sample_mode;
   logic [2:0] parameter_selector;
   logic low_high_select;
   logic [7:0] captured;
   logic monitor_enable;
   logic irq_enable;
   logic thr_wr;
   logic [7:0] thr_rd;
   logic [8*lqta_pkg::NUM_THR-1:0] thr_all;
   logic [lqta_pkg::NUM_THR-1:0] warn;
   logic [8*lqta_pkg::NUM_PARAMS-1:0] params;
   logic [15:0] thr_view;
   logic [15:0] mon_view;
   logic ar_hs;
   logic mon_clear;
   logic rd_was_thr;

   assign params = {freq_control_level, freq_offset_level, baseline_wander_level,
                    gain_control_level, equalizer_coefficient};

   function automatic logic [7:0] param_of(input logic [2:0] sel,
                                           input logic [8*lqta_pkg::NUM_PARAMS-1:0] p);
      case (sel)
         lqta_pkg::LQTA_EQ_COEF: param_of = p[7:0];
         lqta_pkg::LQTA_GAIN: param_of = p[15:8];
         lqta_pkg::LQTA_BLW: param_of = p[23:16];
         lqta_pkg::LQTA_FOFS: param_of = p[31:24];
         lqta_pkg::LQTA_FCTL: param_of = p[39:32];
         default: param_of = 8'h00;
      endcase
   endfunction

   // Write address and data channels, taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         aw_held <= 1'b0;
         aw_addr <= '0;
      end else begin
         if (awvalid && awready) begin
            awready <= 1'b0;
            aw_held <= 1'b1;
            aw_addr <= awaddr;
         end else if (wr_do) begin
            aw_held <= 1'b0;
         end else if (bvalid && bready) begin
            awready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready <= 1'b1;
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
      end else begin
         if (wvalid && wready) begin
            wready <= 1'b0;
            w_held <= 1'b1;
            w_data <= wdata;
            w_strb <= wstrb;
         end else if (wr_do) begin
            w_held <= 1'b0;
         end else if (bvalid && bready) begin
            wready <= 1'b1;
         end
      end
   end

   always_comb begin
      wr_do = aw_held && w_held && !bvalid;
      hit_thr = lqta_pkg::reg_hit(aw_addr, lqta_pkg::IDX_THR_ACCESS);
      hit_mon = lqta_pkg::reg_hit(aw_addr, lqta_pkg::IDX_MONITOR);
      hit_irq = lqta_pkg::reg_hit(aw_addr, lqta_pkg::IDX_IRQ_ENABLE);
      // Byte lanes merge over the current view
      next_ctl[7:0] = w_strb[0] ? w_data[7:0] : thr_view[7:0];
      next_ctl[15:8] = w_strb[1] ? w_data[15:8] : thr_view[15:8];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= lqta_pkg::RESP_OKAY;
      end else if (wr_do) begin
         bvalid <= 1'b1;
         bresp <= (hit_thr || hit_mon || hit_irq) ? lqta_pkg::RESP_OKAY
                                                  : lqta_pkg::RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // Access register fields; the strobe and top bits are never stored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sample_mode <= 1'b0;
         parameter_selector <= 3'h0;
         low_high_select <= 1'b0;
      end else if (wr_do && hit_thr) begin
         sample_mode <= next_ctl[lqta_pkg::SAMPLE_BIT];
         parameter_selector <= next_ctl[lqta_pkg::PSEL_HI:lqta_pkg::PSEL_LO];
         low_high_select <= next_ctl[lqta_pkg::HL_BIT];
      end
   end

   // Captured value only moves on a new sampling request
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         captured <= 8'h00;
      end else if (wr_do && hit_thr && next_ctl[lqta_pkg::SAMPLE_BIT]) begin
         captured <= param_of(next_ctl[lqta_pkg::PSEL_HI:lqta_pkg::PSEL_LO], params);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         monitor_enable <= 1'b0;
         irq_enable <= 1'b0;
      end else if (wr_do && hit_mon && w_strb[1]) begin
         monitor_enable <= w_data[lqta_pkg::MON_EN_BIT];
      end else if (wr_do && hit_irq && w_strb[0]) begin
         irq_enable <= w_data[lqta_pkg::IRQ_EN_BIT];
      end
   end

   // Strobe acts only in the write cycle and only when powered up
   assign thr_wr = wr_do && hit_thr && next_ctl[lqta_pkg::STROBE_BIT] && !pwr_down
                   && lqta_pkg::psel_valid(next_ctl[lqta_pkg::PSEL_HI:lqta_pkg::PSEL_LO]);

   lqta_thr_store u_store (
      .aclk(aclk),
      .aresetn(aresetn),
      .wr_en(thr_wr),
      .wr_idx(next_ctl[lqta_pkg::PSEL_HI:lqta_pkg::HL_BIT]),
      .wr_data(next_ctl[lqta_pkg::DATA_HI:0]),
      .rd_idx({parameter_selector, low_high_select}),
      .rd_data(thr_rd),
      .thr_all(thr_all)
   );

   lqta_monitor u_monitor (
      .aclk(aclk),
      .aresetn(aresetn),
      .active(monitor_enable && link_100_ok),
      .clear(mon_clear),
      .params(params),
      .thr_all(thr_all),
      .warn(warn)
   );

   // Read views; bits 15:14 and the strobe stay zero in the access view
   always_comb begin
      thr_view = 16'h0000;
      thr_view[lqta_pkg::SAMPLE_BIT] = sample_mode;
      thr_view[lqta_pkg::STROBE_BIT] = 1'b0;
      thr_view[lqta_pkg::PSEL_HI:lqta_pkg::PSEL_LO] = parameter_selector;
      thr_view[lqta_pkg::HL_BIT] = low_high_select;
      thr_view[lqta_pkg::DATA_HI:0] = sample_mode ? captured : thr_rd;
      mon_view = {monitor_enable, 5'h00, warn};
   end

   assign ar_hs = arvalid && arready;
   assign mon_clear = ar_hs && lqta_pkg::reg_hit(araddr, lqta_pkg::IDX_MONITOR);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= lqta_pkg::RESP_OKAY;
         rd_was_thr <= 1'b0;
      end else if (ar_hs) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rresp <= lqta_pkg::RESP_OKAY;
         rd_was_thr <= lqta_pkg::reg_hit(araddr, lqta_pkg::IDX_THR_ACCESS);
         if (lqta_pkg::reg_hit(araddr, lqta_pkg::IDX_THR_ACCESS)) begin
            rdata <= {16'h0000, thr_view};
         end else if (lqta_pkg::reg_hit(araddr, lqta_pkg::IDX_MONITOR)) begin
            rdata <= {16'h0000, mon_view};
         end else if (lqta_pkg::reg_hit(araddr, lqta_pkg::IDX_IRQ_ENABLE)) begin
            rdata <= {31'h00000000, irq_enable};
         end else begin
            rdata <= '0;
            rresp <= lqta_pkg::RESP_SLVERR;
         end
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lq_irq <= 1'b0;
      end else begin
         lq_irq <= irq_enable && (|warn);
      end
   end

   chk_rsvd_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      rvalid && rd_was_thr |-> rdata[15:14] == 2'h0)
      else $error("reserved bits not zero");
   chk_strobe_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      rvalid && rd_was_thr |-> !rdata[lqta_pkg::STROBE_BIT])
      else $error("strobe read back as one");
   chk_sample_take: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_do && hit_thr && next_ctl[13] |=> sample_mode
      && captured == param_of($past(next_ctl[11:9]), $past(params)))
      else $error("sample not captured");
   chk_thr_index: assert property (@(posedge aclk) disable iff (!aresetn)
      thr_wr |-> ##1 u_store.thr[$past(next_ctl[11:8])] == $past(next_ctl[7:0]))
      else $error("wrong threshold written");
   chk_thr_read: assert property (@(posedge aclk) disable iff (!aresetn)
      mon_clear == 1'b0 && ar_hs && !sample_mode && lqta_pkg::reg_hit(araddr, 8'h1e)
      |=> rdata[7:0] == $past(thr_rd))
      else $error("threshold readback wrong");
   chk_sample_read: assert property (@(posedge aclk) disable iff (!aresetn)
      ar_hs && sample_mode && lqta_pkg::reg_hit(araddr, 8'h1e)
      |=> rdata[7:0] == $past(captured))
      else $error("sample readback wrong");
   chk_capture_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      !(wr_do && hit_thr && next_ctl[13]) |=> $stable(captured))
      else $error("captured value moved");
   chk_pwrdn_block: assert property (@(posedge aclk) disable iff (!aresetn)
      pwr_down |-> !thr_wr)
      else $error("threshold written while powered down");
   chk_irq_follow: assert property (@(posedge aclk) disable iff (!aresetn)
      irq_enable && (|warn) |=> lq_irq)
      else $error("interrupt not raised");
   chk_reset_fields: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(!aresetn) |-> !sample_mode && parameter_selector == 3'h0 && !low_high_select)
      else $error("fields not reset");

   cov_thr_write: cover property (@(posedge aclk) disable iff (!aresetn) thr_wr);
   cov_sample: cover property (@(posedge aclk) disable iff (!aresetn)
      wr_do && hit_thr && next_ctl[13]);
   cov_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(lq_irq));
   cov_warn_clear: cover property (@(posedge aclk) disable iff (!aresetn) mon_clear && (|warn));
endmodule
`default_nettype wire

/* File: test/lqta_top_test.sv */
// Self-checking testbench for the link quality threshold access register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin checked++; if ((got) !== (exp)) begin fails++; $display("unexpected %s expected %h seen %h", what, exp, got); end end
module lqta_top_test;
   localparam logic [7:0] A_MON = lqta_pkg::IDX_MONITOR << 2;
   localparam logic [7:0] A_THR = lqta_pkg::IDX_THR_ACCESS << 2;
   localparam logic [7:0] A_IRQ = lqta_pkg::IDX_IRQ_ENABLE << 2;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h3;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic pwr_down = 1'b0;
   logic link_100_ok = 1'b1;
   logic [7:0] live [5] = '{8'h40, 8'h40, 8'h40, 8'h40, 8'h40};
   logic awready, wready, bvalid, arready, rvalid, lq_irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int fails = 0;
   int checked = 0;

   always #2 aclk = ~aclk;

   lqta_top u_dut (
      .aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .pwr_down(pwr_down), .link_100_ok(link_100_ok),
      .equalizer_coefficient(live[0]), .gain_control_level(live[1]),
      .baseline_wander_level(live[2]), .freq_offset_level(live[3]),
      .freq_control_level(live[4]), .lq_irq(lq_irq)
   );

   function automatic logic [31:0] word(input logic s, input logic t, input logic [2:0] p,
                                         input logic h, input logic [7:0] d);
      word = {18'h0, s, t, p, h, d};
   endfunction

   // Handshakes judged on settled values before the edge, free of races
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      logic aw_go;
      logic w_go;
      logic b_go;
      n = 0;
      b_go = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(negedge aclk);
         aw_go = awvalid && awready;
         w_go = wvalid && wready;
         b_go = (bvalid === 1'b1);
         r = bresp;
         @(posedge aclk);
         n++;
         if (aw_go) awvalid <= 1'b0;
         if (w_go) wvalid <= 1'b0;
      end while (!b_go && n < 50);
      `CHK("write response", 1'b1, b_go)
      bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      logic ar_go;
      logic r_go;
      n = 0;
      r_go = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge aclk);
         ar_go = arvalid && arready;
         r_go = (rvalid === 1'b1);
         d = rdata;
         r = rresp;
         @(posedge aclk);
         n++;
         if (ar_go) arvalid <= 1'b0;
      end while (!r_go && n < 50);
      `CHK("read response", 1'b1, r_go)
      rready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic t_reset;
      logic [31:0] d;
      logic [1:0] r;
      rd(A_THR, d, r);
      `CHK("access reset", 32'h0, d)
      `CHK("access resp", lqta_pkg::RESP_OKAY, r)
   endtask

   task automatic t_monitor;
      logic [31:0] d;
      logic [1:0] r;
      wr(A_MON, 32'h8000, r);
      wr(A_IRQ, 32'h1, r);
      repeat (4) @(posedge aclk);
      `CHK("irq extreme thresholds", 1'b0, lq_irq)
      wr(A_THR, word(0, 1, 3'b001, 1, 8'h30), r);
      repeat (4) @(posedge aclk);
      `CHK("irq gain high", 1'b1, lq_irq)
      rd(A_MON, d, r);
      `CHK("gain high warning", 32'h8008, d)
      link_100_ok <= 1'b0;
      @(posedge aclk);
      rd(A_MON, d, r);
      rd(A_MON, d, r);
      `CHK("warning without link", 32'h8000, d)
      wr(A_THR, word(0, 1, 3'b001, 1, 8'hff), r);
      link_100_ok <= 1'b1;
      repeat (4) @(posedge aclk);
      `CHK("irq after clear", 1'b0, lq_irq)
   endtask

   task automatic t_fields;
      logic [31:0] d;
      logic [1:0] r;
      wr(A_THR, 32'h0000d3aa, r);
      `CHK("field write resp", lqta_pkg::RESP_OKAY, r)
      rd(A_THR, d, r);
      `CHK("top bits and strobe", 32'h000003aa, d)
   endtask

   task automatic t_all_thr;
      logic [31:0] d;
      logic [1:0] r;
      for (int i = 0; i < 10; i++) begin
         wr(A_THR, word(0, 1, 3'(i / 2), i[0], 8'(8'h20 + i)), r);
      end
      wr(A_THR, word(0, 1, 3'b101, 0, 8'h99), r);
      `CHK("bad select resp", lqta_pkg::RESP_OKAY, r)
      for (int i = 0; i < 10; i++) begin
         wr(A_THR, word(0, 0, 3'(i / 2), i[0], 8'h00), r);
         rd(A_THR, d, r);
         `CHK("threshold", word(0, 0, 3'(i / 2), i[0], 8'(8'h20 + i)), d)
      end
   endtask

   task automatic t_pwr;
      logic [31:0] d;
      logic [1:0] r;
      pwr_down <= 1'b1;
      @(posedge aclk);
      wr(A_THR, word(0, 1, 3'b010, 1, 8'h77), r);
      pwr_down <= 1'b0;
      wr(A_THR, word(0, 0, 3'b010, 1, 8'h00), r);
      rd(A_THR, d, r);
      `CHK("powered down write", word(0, 0, 3'b010, 1, 8'h25), d)
   endtask

   task automatic t_sample;
      logic [31:0] d;
      logic [1:0] r;
      for (int i = 0; i < 5; i++) live[i] <= 8'(8'h61 + i);
      @(posedge aclk);
      for (int i = 0; i < 5; i++) begin
         wr(A_THR, word(1, 0, 3'(i), 0, 8'h00), r);
         rd(A_THR, d, r);
         `CHK("sampled value", word(1, 0, 3'(i), 0, 8'(8'h61 + i)), d)
      end
      wr(A_THR, word(1, 0, 3'b010, 0, 8'h00), r);
      live[2] <= 8'he0;
      repeat (3) @(posedge aclk);
      rd(A_THR, d, r);
      `CHK("held sample", word(1, 0, 3'b010, 0, 8'h63), d)
      wr(A_THR, word(1, 0, 3'b010, 0, 8'h00), r);
      rd(A_THR, d, r);
      `CHK("new sample", word(1, 0, 3'b010, 0, 8'he0), d)
   endtask

   task automatic t_unmapped;
      logic [31:0] d;
      logic [1:0] r;
      wr(8'h40, 32'h00001234, r);
      `CHK("unmapped write resp", lqta_pkg::RESP_SLVERR, r)
      rd(8'h40, d, r);
      `CHK("unmapped read resp", lqta_pkg::RESP_SLVERR, r)
      `CHK("unmapped read data", 32'h0, d)
   endtask

   task automatic tally_and_finish;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset;
      t_monitor;
      t_fields;
      t_all_thr;
      t_pwr;
      t_sample;
      t_unmapped;
      tally_and_finish;
   end

   // Cuts a hung handshake short
   initial begin
      repeat (20000) @(posedge aclk);
      fails++;
      tally_and_finish;
   end
endmodule
`default_nettype wire
